// File: sti_pkg.sv
// sti_pkg: register map, field layout, entry records and helpers for the
// switch table indirect access block.
// assumes a 16-bit byte address on the register port with 32-bit aligned words.
`default_nettype none
package sti_pkg;
	// register byte offsets
	localparam logic [15:0] STI_VLAN_W0_OFS = 16'h0400;
	localparam logic [15:0] STI_VLAN_W1_OFS = 16'h0404;
	localparam logic [15:0] STI_VLAN_W2_OFS = 16'h0408;
	localparam logic [15:0] STI_VLAN_IDX_OFS = 16'h040c;
	localparam logic [15:0] STI_VLAN_ACC_OFS = 16'h0410;
	localparam logic [15:0] STI_MODE_OFS = 16'h0414;
	localparam logic [15:0] STI_CTRL_OFS = 16'h041c;
	localparam logic [15:0] STI_FWD_OFS = 16'h0424;
	localparam logic [15:0] STI_GRP_OFS = 16'h0428;
	localparam logic [15:0] STI_MACL_OFS = 16'h042c;

	// control register of the static / reserved multicast tables
	localparam int STI_SEL_LSB = 0;
	localparam int STI_SEL_W = 6;
	localparam int STI_GO_BIT = 7;
	localparam int STI_CHOOSE_BIT = 8;
	localparam int STI_ACT_BIT = 9;
	// vlan access control and mode registers
	localparam int STI_VACT_BIT = 0;
	localparam int STI_VGO_BIT = 7;
	localparam int STI_MODE_BIT = 0;

	// forwarding word
	localparam int STI_BYPASS_BIT = 31;
	localparam int STI_FMATCH_BIT = 30;
	localparam int STI_NPORTS = 7;
	// group / mac-high word
	localparam int STI_FID_LSB = 16;
	localparam int STI_FID_W = 7;
	localparam int STI_MACH_W = 16;
	// vlan word 0
	localparam int STI_VVALID_BIT = 31;
	localparam int STI_VCHOICE_BIT = 30;
	localparam int STI_VPRIO_LSB = 27;
	localparam int STI_VMSTI_LSB = 24;

	localparam int STI_STATIC_ENTRIES = 16;
	localparam int STI_MCAST_ENTRIES = 48;
	localparam int STI_MCAST_GROUPS = 8;
	localparam int STI_VLAN_ENTRIES = 4096;
	localparam int STI_VID_W = 12;
	localparam logic [39:0] STI_MCAST_PREFIX = 40'h0180c20000;
	localparam logic [31:0] STI_RESET_WORD = 32'h0000_0000;

	typedef struct packed {
		logic       valid;
		logic       fwd_choice;
		logic [2:0] prio;
		logic [2:0] msti;
		logic [6:0] filter_group_id;
		logic [6:0] strip;
		logic [6:0] member;
	} sti_vlan_entry_t;

	typedef struct packed {
		logic        bypass;
		logic        fmatch;
		logic [6:0]  filter_group_id;
		logic [6:0]  mask;
		logic [47:0] mac;
	} sti_static_entry_t;

	typedef struct packed {
		logic            vlan_hit;
		sti_vlan_entry_t vlan;
		logic            static_hit;
		logic            bypass;
		logic [6:0]      static_mask;
		logic            mcast_hit;
		logic [6:0]      mcast_mask;
	} sti_lookup_res_t;

	// fixed address-to-group map of the reserved multicast table
	function automatic logic [2:0] sti_mcast_group(input logic [5:0] idx);
		return idx[2:0];
	endfunction

	function automatic logic sti_is_reserved(input logic [47:0] mac);
		return (mac[47:8] == STI_MCAST_PREFIX) && (mac[7:0] < 8'(STI_MCAST_ENTRIES));
	endfunction
endpackage
`default_nettype wire

// File: sti_vlan_ram.sv
// sti_vlan_ram: vlan table storage, one read/write port for software and
// one read port for the per-packet lookup, both with one cycle read latency.
// assumes the caller holds ce low to freeze the whole block.
`timescale 1ns/10ps
`default_nettype none
module sti_vlan_ram #(
	parameter int DEPTH = 4096,
	parameter int AW    = 12
) (
	input  wire logic                     clk_sys,
	input  wire logic                     ce,
	input  wire logic                     a_we,
	input  wire logic [AW-1:0]            a_addr,
	input  wire sti_pkg::sti_vlan_entry_t a_wdata,
	output var  sti_pkg::sti_vlan_entry_t a_rdata_q,
	input  wire logic [AW-1:0]            b_addr,
	output var  sti_pkg::sti_vlan_entry_t b_rdata_q
);
	if (DEPTH != (1 << AW)) begin : g_bad_depth
		$error("sti_vlan_ram: depth must equal 2**AW");
	end

	// no reset on the array: software must load it before the mode is enabled
	sti_pkg::sti_vlan_entry_t mem [DEPTH];

	always_ff @(posedge clk_sys) begin
		if (ce) begin
			if (a_we) begin
				mem[a_addr] <= a_wdata;
			end
			a_rdata_q <= mem[a_addr];
			b_rdata_q <= mem[b_addr];
		end
	end
endmodule // sti_vlan_ram
`default_nettype wire

// File: sti_table_access.sv
// sti_table_access: indirect access to the static address, reserved multicast
// and vlan tables, plus the per-packet lookup of all three.
// assumes a same-clock register master and same-clock lookup requests.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - forward word bit 31 bypasses port state
// - bit 30 adds group id to multicast match
// - bits 6:0 egress mask, bit0 port1
// - third word: group id, mac high, zeros
// - fourth word holds mac low, resets zero
// - reserved table indexed by low six bits
// - mask write changes whole fixed group
// - reserved table shares control and forward word
// - go bit self clears on completion
// - vlan lookup only when mode enabled
// - 4096 vlan entries indexed by vid
// - vlan entry valid flag
// - vlan membership forward choice bit
// - vlan priority and spanning tree instance
// - vlan filter group id
// - vlan egress tag strip mask
// - vlan port membership mask, bit0 port1
// - vlan write via index, start bit 7
// - vlan read via start bit 7, poll
module sti_table_access #(
	parameter int VLAN_ENTRIES = sti_pkg::STI_VLAN_ENTRIES,
	parameter int VID_W        = sti_pkg::STI_VID_W
) (
	input  wire logic                   clk_sys,
	input  wire logic                   rst_b,
	input  wire logic                   ce,
	input  wire logic [15:0]            addr,
	input  wire logic [31:0]            wr_data,
	input  wire logic                   wr_en,
	input  wire logic                   rd_en,
	output logic [31:0]                 rd_data_q,
	input  wire logic                   lk_req,
	input  wire logic [47:0]            lk_mac,
	input  wire logic [6:0]             lk_fid,
	input  wire logic [VID_W-1:0]       lk_vid,
	output logic                        lk_valid_q,
	output sti_pkg::sti_lookup_res_t    lk_res_q
);
	if (VLAN_ENTRIES != (1 << VID_W)) begin : g_bad_vlan
		$error("sti_table_access: vlan entries must equal 2**VID_W");
	end

	typedef enum logic [1:0] {
		STI_VL_IDLE    = 2'b00,
		STI_VL_ACCESS  = 2'b01,
		STI_VL_CAPTURE = 2'b11
	} sti_vl_state_t;

	// static / reserved multicast engine
	logic                       st_go_q;
	logic                       st_read_q;
	logic                       st_choose_q;
	logic [5:0]                 st_sel_q;
	logic                       byp_q;
	logic                       fmatch_q;
	logic [6:0]                 fwd_mask_q;
	logic [6:0]                 fid_q;
	logic [15:0]                mach_q;
	logic [31:0]                macl_q;
	logic [15:0]                st_used_q;
	logic [6:0]                 mc_mask_q [sti_pkg::STI_MCAST_GROUPS];
	sti_pkg::sti_static_entry_t st_mem [sti_pkg::STI_STATIC_ENTRIES];
	// vlan engine
	sti_vl_state_t              vl_state_q;
	sti_vl_state_t              vl_state_d;
	logic                       vl_read_q;
	logic                       mode_q;
	logic [VID_W-1:0]           vidx_q;
	sti_pkg::sti_vlan_entry_t   vent_q;
	sti_pkg::sti_vlan_entry_t   vram_a_q;
	sti_pkg::sti_vlan_entry_t   vram_b_q;
	// lookup pipeline
	logic                       lk_p1_q;
	logic                       lk_vlan_q;
	sti_pkg::sti_lookup_res_t   lk_p1_res_q;
	logic                       sm_hit;
	logic                       sm_byp;
	logic [6:0]                 sm_mask;

	wire wr_ctrl  = wr_en && (addr == sti_pkg::STI_CTRL_OFS);
	wire wr_fwd   = wr_en && (addr == sti_pkg::STI_FWD_OFS);
	wire wr_grp   = wr_en && (addr == sti_pkg::STI_GRP_OFS);
	wire wr_macl  = wr_en && (addr == sti_pkg::STI_MACL_OFS);
	wire wr_vw0   = wr_en && (addr == sti_pkg::STI_VLAN_W0_OFS);
	wire wr_vw1   = wr_en && (addr == sti_pkg::STI_VLAN_W1_OFS);
	wire wr_vw2   = wr_en && (addr == sti_pkg::STI_VLAN_W2_OFS);
	wire wr_vidx  = wr_en && (addr == sti_pkg::STI_VLAN_IDX_OFS);
	wire wr_vacc  = wr_en && (addr == sti_pkg::STI_VLAN_ACC_OFS);
	wire wr_mode  = wr_en && (addr == sti_pkg::STI_MODE_OFS);
	wire vl_busy  = (vl_state_q != STI_VL_IDLE);
	// a start is taken only while idle; later starts are dropped
	wire st_start = wr_ctrl && wr_data[sti_pkg::STI_GO_BIT] && !st_go_q;
	wire vl_start = wr_vacc && wr_data[sti_pkg::STI_VGO_BIT] && !vl_busy;
	wire st_done  = st_go_q;
	wire st_hold  = st_go_q;
	wire vl_hold  = vl_busy;
	wire [2:0] mc_grp = sti_pkg::sti_mcast_group(st_sel_q);
	wire [3:0] st_idx = st_sel_q[3:0];
	wire sti_pkg::sti_static_entry_t st_rd = st_mem[st_idx];
	wire [VID_W-1:0] vram_addr = vidx_q;

	// static / reserved control register
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			st_go_q     <= 1'b0;
			st_read_q   <= 1'b0;
			st_choose_q <= 1'b0;
			st_sel_q    <= '0;
		end else if (ce) begin
			if (st_start) begin
				st_go_q     <= 1'b1;
				st_read_q   <= wr_data[sti_pkg::STI_ACT_BIT];
				st_choose_q <= wr_data[sti_pkg::STI_CHOOSE_BIT];
				st_sel_q    <= wr_data[sti_pkg::STI_SEL_LSB +: sti_pkg::STI_SEL_W];
			end else if (st_done) begin
				st_go_q <= 1'b0;
			end
		end
	end

	// data words: the bus loads them while idle, a finished read loads the entry
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			byp_q      <= 1'b0;
			fmatch_q   <= 1'b0;
			fwd_mask_q <= '0;
			fid_q      <= '0;
			mach_q     <= '0;
			macl_q     <= sti_pkg::STI_RESET_WORD;
		end else if (ce) begin
			if (st_done && st_read_q && st_choose_q) begin
				byp_q      <= 1'b0;
				fmatch_q   <= 1'b0;
				fwd_mask_q <= mc_mask_q[mc_grp];
			end else if (st_done && st_read_q) begin
				byp_q      <= st_rd.bypass;
				fmatch_q   <= st_rd.fmatch;
				fwd_mask_q <= st_rd.mask;
				fid_q      <= st_rd.filter_group_id;
				mach_q     <= st_rd.mac[47:32];
				macl_q     <= st_rd.mac[31:0];
			end else if (!st_hold) begin
				if (wr_fwd) begin
					byp_q      <= wr_data[sti_pkg::STI_BYPASS_BIT];
					fmatch_q   <= wr_data[sti_pkg::STI_FMATCH_BIT];
					fwd_mask_q <= wr_data[sti_pkg::STI_NPORTS-1:0];
				end
				if (wr_grp) begin
					fid_q  <= wr_data[sti_pkg::STI_FID_LSB +: sti_pkg::STI_FID_W];
					mach_q <= wr_data[sti_pkg::STI_MACH_W-1:0];
				end
				if (wr_macl) begin
					macl_q <= wr_data;
				end
			end
		end
	end

	// table storage; one mask per group so a write reaches every member address
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			st_used_q <= '0;
			for (int g = 0; g < sti_pkg::STI_MCAST_GROUPS; g++) begin
				mc_mask_q[g] <= '0;
			end
		end else if (ce && st_done && !st_read_q) begin
			if (st_choose_q) begin
				mc_mask_q[mc_grp] <= fwd_mask_q;
			end else begin
				st_used_q[st_idx] <= 1'b1;
				st_mem[st_idx]    <= '{byp_q, fmatch_q, fid_q, fwd_mask_q, {mach_q, macl_q}};
			end
		end
	end

	// vlan access engine
	always_comb begin
		vl_state_d = vl_state_q;
		unique case (vl_state_q)
			STI_VL_IDLE:    if (vl_start) vl_state_d = STI_VL_ACCESS;
			STI_VL_ACCESS:  vl_state_d = STI_VL_CAPTURE;
			STI_VL_CAPTURE: vl_state_d = STI_VL_IDLE;
			default:        vl_state_d = STI_VL_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			vl_state_q <= STI_VL_IDLE;
			vl_read_q  <= 1'b0;
			mode_q     <= 1'b0;
			vidx_q     <= '0;
			vent_q     <= '0;
		end else if (ce) begin
			vl_state_q <= vl_state_d;
			if (vl_start) begin
				vl_read_q <= wr_data[sti_pkg::STI_VACT_BIT];
			end
			if (wr_mode) begin
				mode_q <= wr_data[sti_pkg::STI_MODE_BIT];
			end
			if (vl_state_q == STI_VL_CAPTURE && vl_read_q) begin
				vent_q <= vram_a_q;
			end else if (!vl_hold) begin
				if (wr_vidx) vidx_q <= wr_data[VID_W-1:0];
				if (wr_vw0) begin
					vent_q.valid      <= wr_data[sti_pkg::STI_VVALID_BIT];
					vent_q.fwd_choice <= wr_data[sti_pkg::STI_VCHOICE_BIT];
					vent_q.prio       <= wr_data[sti_pkg::STI_VPRIO_LSB +: 3];
					vent_q.msti       <= wr_data[sti_pkg::STI_VMSTI_LSB +: 3];
					vent_q.filter_group_id        <= wr_data[sti_pkg::STI_FID_W-1:0];
				end
				if (wr_vw1) vent_q.strip  <= wr_data[sti_pkg::STI_NPORTS-1:0];
				if (wr_vw2) vent_q.member <= wr_data[sti_pkg::STI_NPORTS-1:0];
			end
		end
	end

	sti_vlan_ram #(
		.DEPTH (VLAN_ENTRIES),
		.AW    (VID_W)
	) u_vlan_ram (
		.clk_sys   (clk_sys),
		.ce        (ce),
		.a_we      (vl_state_q == STI_VL_ACCESS && !vl_read_q),
		.a_addr    (vram_addr),
		.a_wdata   (vent_q),
		.a_rdata_q (vram_a_q),
		.b_addr    (lk_vid),
		.b_rdata_q (vram_b_q)
	);

	// static match: lowest matching entry wins
	always_comb begin
		sm_hit  = 1'b0;
		sm_byp  = 1'b0;
		sm_mask = '0;
		for (int i = sti_pkg::STI_STATIC_ENTRIES - 1; i >= 0; i--) begin
			if (st_used_q[i] && st_mem[i].mac == lk_mac &&
			    (!(lk_mac[40] && st_mem[i].fmatch) || st_mem[i].filter_group_id == lk_fid)) begin
				sm_hit  = 1'b1;
				sm_byp  = st_mem[i].bypass;
				sm_mask = st_mem[i].mask;
			end
		end
	end

	// two-stage lookup: the vlan array answers one cycle after the request
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			lk_p1_q     <= 1'b0;
			lk_vlan_q   <= 1'b0;
			lk_p1_res_q <= '0;
			lk_valid_q  <= 1'b0;
			lk_res_q    <= '0;
		end else if (ce) begin
			lk_p1_q                 <= lk_req;
			lk_vlan_q               <= lk_req && mode_q;
			lk_p1_res_q.static_hit  <= sm_hit;
			lk_p1_res_q.bypass      <= sm_byp;
			lk_p1_res_q.static_mask <= sm_mask;
			lk_p1_res_q.mcast_hit   <= sti_pkg::sti_is_reserved(lk_mac);
			lk_p1_res_q.mcast_mask  <= mc_mask_q[sti_pkg::sti_mcast_group(lk_mac[5:0])];
			lk_valid_q              <= lk_p1_q;
			lk_res_q                <= lk_p1_res_q;
			lk_res_q.vlan_hit       <= lk_vlan_q && vram_b_q.valid;
			lk_res_q.vlan           <= lk_vlan_q ? vram_b_q : '0;
		end
	end

	// read data, reserved bits as zero
	wire [31:0] rd_mux =
		(addr == sti_pkg::STI_CTRL_OFS) ? {22'h0, st_read_q, st_choose_q, st_go_q, 1'b0, st_sel_q} :
		(addr == sti_pkg::STI_FWD_OFS)  ? {byp_q, fmatch_q, 23'h0, fwd_mask_q} :
		(addr == sti_pkg::STI_GRP_OFS)  ? {9'h0, fid_q, mach_q} :
		(addr == sti_pkg::STI_MACL_OFS) ? macl_q :
		(addr == sti_pkg::STI_VLAN_W0_OFS) ?
			{vent_q.valid, vent_q.fwd_choice, vent_q.prio, vent_q.msti, 17'h0, vent_q.filter_group_id} :
		(addr == sti_pkg::STI_VLAN_W1_OFS) ? {25'h0, vent_q.strip} :
		(addr == sti_pkg::STI_VLAN_W2_OFS) ? {25'h0, vent_q.member} :
		(addr == sti_pkg::STI_VLAN_IDX_OFS) ? {20'h0, vidx_q} :
		(addr == sti_pkg::STI_VLAN_ACC_OFS) ? {24'h0, vl_busy, 6'h0, vl_read_q} :
		(addr == sti_pkg::STI_MODE_OFS) ? {31'h0, mode_q} : 32'h0000_0000;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rd_data_q <= '0;
		end else if (ce) begin
			rd_data_q <= rd_en ? rd_mux : 32'h0000_0000;
		end
	end

	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b || !ce);

	property p_go_clear;
		st_go_q |=> !st_go_q;
	endproperty
	a_go_clear: assert property (p_go_clear) else $error("static go bit did not clear");

	property p_vlan_done;
		vl_start |=> vl_busy ##1 vl_busy ##1 !vl_busy;
	endproperty
	a_vlan_done: assert property (p_vlan_done) else $error("vlan start bit timing wrong");

	property p_hold_data;
		st_go_q && !st_read_q |=> $stable(macl_q) && $stable(fwd_mask_q) && $stable(fid_q);
	endproperty
	a_hold_data: assert property (p_hold_data) else $error("data word changed while busy");

	property p_ignore_start;
		st_go_q && wr_ctrl |=> $stable(st_sel_q) && $stable(st_choose_q);
	endproperty
	a_ignore_start: assert property (p_ignore_start) else $error("start taken while busy");

	property p_grp_zero;
		rd_en && addr == sti_pkg::STI_GRP_OFS |=> rd_data_q[31:23] == 9'h0 && rd_data_q[15:0] == $past(mach_q);
	endproperty
	a_grp_zero: assert property (p_grp_zero) else $error("group word reserved bits set");

	property p_macl_rw;
		wr_macl && !st_go_q |=> macl_q == $past(wr_data);
	endproperty
	a_macl_rw: assert property (p_macl_rw) else $error("mac low word not stored");

	property p_grp_write;
		st_go_q && st_choose_q && !st_read_q |=> mc_mask_q[$past(mc_grp)] == $past(fwd_mask_q);
	endproperty
	a_grp_write: assert property (p_grp_write) else $error("group mask not written");

	property p_mode_gate;
		lk_valid_q && lk_res_q.vlan_hit |-> $past(mode_q, 2);
	endproperty
	a_mode_gate: assert property (p_mode_gate) else $error("vlan hit while mode off");

	property p_lk_latency;
		lk_req |-> ##2 lk_valid_q;
	endproperty
	a_lk_latency: assert property (p_lk_latency) else $error("lookup answer late");

	property p_bypass_hit;
		lk_valid_q && lk_res_q.bypass |-> lk_res_q.static_hit;
	endproperty
	a_bypass_hit: assert property (p_bypass_hit) else $error("bypass without static hit");

	c_mcast_write: cover property (st_go_q && st_choose_q && !st_read_q);
	c_vlan_read: cover property (vl_state_q == STI_VL_CAPTURE && vl_read_q);
	c_static_hit: cover property (lk_valid_q && lk_res_q.static_hit);
endmodule // sti_table_access
`default_nettype wire

// File: sti_table_access_tb_top.sv
// sti_table_access_tb_top: self-checking bench for the table indirect access block.
// assumes the block alone, register port and lookup port driven straight from here.
`timescale 1ns/10ps
`default_nettype none
module sti_table_access_tb_top;
	logic                     clk_sys = 1'b0;
	logic                     rst_b = 1'b0;
	logic                     ce = 1'b1;
	logic [15:0]              addr = 16'h0000;
	logic [31:0]              wr_data = 32'h0000_0000;
	logic                     wr_en = 1'b0;
	logic                     rd_en = 1'b0;
	logic [31:0]              rd_data_q;
	logic                     lk_req = 1'b0;
	logic [47:0]              lk_mac = 48'h0000_0000_0000;
	logic [6:0]               lk_fid = 7'h00;
	logic [11:0]              lk_vid = 12'h000;
	logic                     lk_valid_q;
	sti_pkg::sti_lookup_res_t lk_res_q;
	sti_pkg::sti_lookup_res_t res;
	sti_pkg::sti_vlan_entry_t ev;
	int                       err_total = 0;
	int                       num_checks = 0;
	int                       cyc = 0;

	sti_table_access i_sti_table_access (
		.clk_sys    (clk_sys),
		.rst_b      (rst_b),
		.ce         (ce),
		.addr       (addr),
		.wr_data    (wr_data),
		.wr_en      (wr_en),
		.rd_en      (rd_en),
		.rd_data_q  (rd_data_q),
		.lk_req     (lk_req),
		.lk_mac     (lk_mac),
		.lk_fid     (lk_fid),
		.lk_vid     (lk_vid),
		.lk_valid_q (lk_valid_q),
		.lk_res_q   (lk_res_q)
	);

	always #10 clk_sys = ~clk_sys;

	task automatic end_of_test();
		if (err_total == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// generous ceiling: the whole sequence needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_of_test();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one bus cycle; the next call overrides the strobes, so back-to-back is possible
	task automatic bus(input logic we, input logic re, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		wr_en <= we;
		rd_en <= re;
		addr <= a;
		wr_data <= d;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		bus(1'b1, 1'b0, a, d);
		bus(1'b0, 1'b0, a, d);
	endtask

	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		bus(1'b0, 1'b1, a, 32'h0000_0000);
		bus(1'b0, 1'b0, a, 32'h0000_0000);
		#1;
		d = rd_data_q;
	endtask

	task automatic rchk(input logic [15:0] a, input logic [31:0] exp, input string what);
		logic [31:0] v;
		rd(a, v);
		chk(what, exp, v);
	endtask

	task automatic poll(input logic [15:0] a, input int b);
		logic [31:0] s;
		int          n;
		n = 0;
		s = 32'hffff_ffff;
		while (s[b] !== 1'b0 && n < 20) begin
			rd(a, s);
			n++;
		end
		chk("start bit cleared", 32'h0000_0000, 32'(s[b]));
	endtask

	task automatic look(input logic [47:0] m, input logic [6:0] f, input logic [11:0] vid);
		int n;
		@(posedge clk_sys);
		lk_req <= 1'b1;
		lk_mac <= m;
		lk_fid <= f;
		lk_vid <= vid;
		@(posedge clk_sys);
		lk_req <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (lk_valid_q !== 1'b1 && n < 4);
		chk("lookup valid", 32'h0000_0001, 32'(lk_valid_q));
		res = lk_res_q;
	endtask

	initial begin
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		rchk(sti_pkg::STI_FWD_OFS, 32'h0000_0000, "fwd word reset");
		rchk(sti_pkg::STI_GRP_OFS, 32'h0000_0000, "group word reset");
		rchk(sti_pkg::STI_MACL_OFS, 32'h0000_0000, "mac low reset");
		wr(16'h0500, 32'hffff_ffff);
		rchk(16'h0500, 32'h0000_0000, "unmapped read");
		wr(sti_pkg::STI_FWD_OFS, 32'hffff_ffff);
		rchk(sti_pkg::STI_FWD_OFS, 32'hc000_007f, "fwd word fields");
		// a write seen while the clock enable is low must not land
		@(posedge clk_sys);
		ce <= 1'b0;
		wr(sti_pkg::STI_FWD_OFS, 32'h0000_0000);
		ce <= 1'b1;
		rchk(sti_pkg::STI_FWD_OFS, 32'hc000_007f, "fwd word frozen by ce");
		wr(sti_pkg::STI_GRP_OFS, 32'hffff_ffff);
		rchk(sti_pkg::STI_GRP_OFS, 32'h007f_ffff, "group word fields");
		wr(sti_pkg::STI_MACL_OFS, 32'hffff_ffff);
		rchk(sti_pkg::STI_MACL_OFS, 32'hffff_ffff, "mac low full width");
		// static entry 3: bypass, mask ports 1,3,5, group 5, mac 00-11-22-33-44-55
		wr(sti_pkg::STI_FWD_OFS, 32'h8000_0015);
		wr(sti_pkg::STI_GRP_OFS, 32'h0005_0011);
		wr(sti_pkg::STI_MACL_OFS, 32'h2233_4455);
		bus(1'b1, 1'b0, sti_pkg::STI_CTRL_OFS, 32'h0000_0083);
		bus(1'b1, 1'b0, sti_pkg::STI_FWD_OFS, 32'h0000_0000);
		bus(1'b0, 1'b0, sti_pkg::STI_FWD_OFS, 32'h0000_0000);
		poll(sti_pkg::STI_CTRL_OFS, sti_pkg::STI_GO_BIT);
		rchk(sti_pkg::STI_FWD_OFS, 32'h8000_0015, "fwd word held while busy");
		look(48'h0011_2233_4455, 7'h00, 12'h000);
		chk("static hit", 32'h1, 32'(res.static_hit));
		chk("static bypass", 32'h1, 32'(res.bypass));
		chk("static mask", 32'h15, 32'(res.static_mask));
		look(48'h0011_2233_4456, 7'h00, 12'h000);
		chk("static miss", 32'h0, 32'(res.static_hit));
		// read entry 3 back after clearing the data words; a second start while busy is dropped
		wr(sti_pkg::STI_FWD_OFS, 32'h0000_0000);
		wr(sti_pkg::STI_GRP_OFS, 32'h0000_0000);
		wr(sti_pkg::STI_MACL_OFS, 32'h0000_0000);
		bus(1'b1, 1'b0, sti_pkg::STI_CTRL_OFS, 32'h0000_0283);
		bus(1'b1, 1'b0, sti_pkg::STI_CTRL_OFS, 32'h0000_0085);
		bus(1'b0, 1'b0, sti_pkg::STI_CTRL_OFS, 32'h0000_0000);
		poll(sti_pkg::STI_CTRL_OFS, sti_pkg::STI_GO_BIT);
		rchk(sti_pkg::STI_CTRL_OFS, 32'h0000_0203, "ctrl kept first start");
		rchk(sti_pkg::STI_FWD_OFS, 32'h8000_0015, "static read fwd");
		rchk(sti_pkg::STI_GRP_OFS, 32'h0005_0011, "static read group");
		rchk(sti_pkg::STI_MACL_OFS, 32'h2233_4455, "static read mac low");
		// static entry 5: multicast mac 01-00-5e-00-00-01, group id 9 must match, ports 2 and 6
		wr(sti_pkg::STI_FWD_OFS, 32'h4000_0022);
		wr(sti_pkg::STI_GRP_OFS, 32'h0009_0100);
		wr(sti_pkg::STI_MACL_OFS, 32'h5e00_0001);
		wr(sti_pkg::STI_CTRL_OFS, 32'h0000_0085);
		poll(sti_pkg::STI_CTRL_OFS, sti_pkg::STI_GO_BIT);
		look(48'h0100_5e00_0001, 7'h09, 12'h000);
		chk("group match hit", 32'h1, 32'(res.static_hit));
		chk("group match mask", 32'h22, 32'(res.static_mask));
		chk("group match bypass", 32'h0, 32'(res.bypass));
		look(48'h0100_5e00_0001, 7'h08, 12'h000);
		chk("group mismatch miss", 32'h0, 32'(res.static_hit));
		// one mask per group, written at the low index and read at index+40 of the same group
		for (int g = 0; g < 8; g++) begin
			wr(sti_pkg::STI_FWD_OFS, 32'h4000_0000 | 32'(g + 1));
			wr(sti_pkg::STI_CTRL_OFS, 32'h0000_0180 | 32'(g));
			poll(sti_pkg::STI_CTRL_OFS, sti_pkg::STI_GO_BIT);
		end
		for (int g = 0; g < 8; g++) begin
			wr(sti_pkg::STI_CTRL_OFS, 32'h0000_0380 | 32'(g + 40));
			poll(sti_pkg::STI_CTRL_OFS, sti_pkg::STI_GO_BIT);
			rchk(sti_pkg::STI_FWD_OFS, 32'(g + 1), "mcast group mask");
		end
		look(48'h0180_c200_0011, 7'h00, 12'h000);
		chk("mcast hit", 32'h1, 32'(res.mcast_hit));
		chk("mcast mask", 32'h02, 32'(res.mcast_mask));
		// vlan entry 0xabc
		ev = '{valid: 1'b1, fwd_choice: 1'b1, prio: 3'h5, msti: 3'h3, filter_group_id: 7'h12, strip: 7'h55, member: 7'h2b};
		wr(sti_pkg::STI_VLAN_W0_OFS, 32'heb00_0012);
		wr(sti_pkg::STI_VLAN_W1_OFS, 32'h0000_0055);
		wr(sti_pkg::STI_VLAN_W2_OFS, 32'h0000_002b);
		wr(sti_pkg::STI_VLAN_IDX_OFS, 32'h0000_0abc);
		wr(sti_pkg::STI_VLAN_ACC_OFS, 32'h0000_0080);
		poll(sti_pkg::STI_VLAN_ACC_OFS, sti_pkg::STI_VGO_BIT);
		wr(sti_pkg::STI_VLAN_W0_OFS, 32'h0000_0000);
		wr(sti_pkg::STI_VLAN_W1_OFS, 32'h0000_0000);
		wr(sti_pkg::STI_VLAN_W2_OFS, 32'h0000_0000);
		wr(sti_pkg::STI_VLAN_ACC_OFS, 32'h0000_0081);
		// lands in the capture cycle of the read, so it must be dropped
		wr(sti_pkg::STI_VLAN_IDX_OFS, 32'h0000_0000);
		poll(sti_pkg::STI_VLAN_ACC_OFS, sti_pkg::STI_VGO_BIT);
		rchk(sti_pkg::STI_VLAN_W0_OFS, 32'heb00_0012, "vlan word0");
		rchk(sti_pkg::STI_VLAN_W1_OFS, 32'h0000_0055, "vlan word1");
		rchk(sti_pkg::STI_VLAN_W2_OFS, 32'h0000_002b, "vlan word2");
		rchk(sti_pkg::STI_VLAN_IDX_OFS, 32'h0000_0abc, "vlan index held while busy");
		look(48'h0011_2233_4455, 7'h00, 12'habc);
		chk("vlan hit mode off", 32'h0, 32'(res.vlan_hit));
		chk("vlan fields mode off", 32'h0, 32'(res.vlan));
		// the table is programmed before the mode goes on
		wr(sti_pkg::STI_MODE_OFS, 32'h0000_0001);
		look(48'h0011_2233_4455, 7'h00, 12'habc);
		chk("vlan hit mode on", 32'h1, 32'(res.vlan_hit));
		chk("vlan entry fields", 32'(ev), 32'(res.vlan));
		// entry 0 written invalid must not hit
		wr(sti_pkg::STI_VLAN_W0_OFS, 32'h0000_0000);
		wr(sti_pkg::STI_VLAN_IDX_OFS, 32'h0000_0000);
		wr(sti_pkg::STI_VLAN_ACC_OFS, 32'h0000_0080);
		poll(sti_pkg::STI_VLAN_ACC_OFS, sti_pkg::STI_VGO_BIT);
		look(48'h0011_2233_4455, 7'h00, 12'h000);
		chk("vlan invalid entry", 32'h0, 32'(res.vlan_hit));
		end_of_test();
	end
endmodule // sti_table_access_tb_top
`default_nettype wire
